/* File: core/gplut_cfg.svh */
// gplut_cfg.svh: offsets, field positions, reset values and codes of the lookup-table block
// assumes byte-wide registers on a 32-bit bus, byte address = 4 * register index
`ifndef GPLUT_CFG_SVH
`define GPLUT_CFG_SVH

// register indices (byte address is four times the index)
`define GPLUT_IDX_MODE        8'h20
`define GPLUT_IDX_LA_TWO      8'h23
`define GPLUT_IDX_UB_THREE    8'h24
`define GPLUT_IDX_UA_THREE    8'h25
`define GPLUT_IDX_LB_THREE    8'h26
`define GPLUT_IDX_LA_THREE    8'h27
`define GPLUT_IDX_PIN_DRIVE   8'h30
`define GPLUT_IDX_PIN_LEVEL   8'h31

// logic mode field positions inside the mode register, two bits each
`define GPLUT_MODE_LA_LSB     0
`define GPLUT_MODE_UA_LSB     2
`define GPLUT_MODE_LB_LSB     4
`define GPLUT_MODE_UB_LSB     6

// reset values
`define GPLUT_TABLE_RST       8'h00
`define GPLUT_MODE_RST        8'h00

// pins per bank and the position of the 2-input decode output in the lower-A bank
`define GPLUT_BANK_PINS       4
`define GPLUT_TWO_OUT_PIN     2

`endif

/* File: core/gplut_pkg.sv */
// gplut_pkg: types shared by the lookup-table block
// assumes gplut_cfg.svh carries every number
package gplut_pkg;

  // per-bank logic mode, codes as stored in the mode register
  typedef enum logic [1:0] {
    GPLUT_MODE_NORMAL = 2'h0,
    GPLUT_MODE_TWO    = 2'h1,
    GPLUT_MODE_THREE  = 2'h2,
    GPLUT_MODE_SPLIT  = 2'h3
  } gplut_mode_t;

  // four banks: lower-a, upper-a, lower-b, upper-b
  typedef enum logic [1:0] {
    GPLUT_BANK_LA = 2'h0,
    GPLUT_BANK_UA = 2'h1,
    GPLUT_BANK_LB = 2'h2,
    GPLUT_BANK_UB = 2'h3
  } gplut_bank_t;

endpackage : gplut_pkg

/* File: core/gplut_lut.sv */
// gplut_lut: one lookup table, picks a table bit by a select index
// assumes the caller registers the result; purely combinational
`timescale 1ns/10ps
module gplut_lut #(
  parameter int SEL_W = 3
) (
  input  wire logic [(1<<SEL_W)-1:0] table_in,
  input  wire logic [SEL_W-1:0]      sel_in,
  output logic                       bit_out
);
  // bit n of the table answers select value n
  assign bit_out = table_in[sel_in];
endmodule : gplut_lut

/* File: core/gplut_avmm_slave.sv */
// gplut_avmm_slave: Avalon-MM slave front end with waitrequest
// assumes a master that holds its request until waitrequest is sampled low
`timescale 1ns/10ps
module gplut_avmm_slave (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [9:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [3:0]  byteenable_in,
  input  wire logic [7:0]  rd_value_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  output logic             wr_strobe_out,
  output logic [7:0]       index_out
);
  logic        req;
  logic        wait_reg;
  logic [31:0] rdata_reg;

  assign req   = read_in | write_in;
  assign index_out = address_in[9:2];
  // write lands at the one edge where the master sees waitrequest low
  assign wr_strobe_out = write_in & ~wait_reg & byteenable_in[0];
  assign waitrequest_out = wait_reg;
  assign readdata_out = rdata_reg;

  // one wait cycle per access; drops low for exactly one cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wait_reg <= 1'h1;
    end else if (req && wait_reg) begin
      wait_reg <= 1'h0;
    end else begin
      wait_reg <= 1'h1;
    end
  end

  // read data captured early so it stands when waitrequest falls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (read_in && wait_reg) begin
      rdata_reg <= {24'h00_0000, rd_value_in};
    end
  end
endmodule : gplut_avmm_slave

/* File: core/gplut_top.sv */
// gplut_top: lookup-table logic for a 16-pin expander, registers on Avalon-MM
// assumes pin levels synchronous to clk_in; pin drivers outside use oe_n/level
`timescale 1ns/10ps
`include "gplut_cfg.svh"

// Summary of operation
// [RULE1] upper-b three-input table drives pin 15
// [RULE2] upper-a three-input table drives pin 7
// [RULE3] lower-b three-input table drives pin 11
// [RULE4] lower-a two-input table drives pin 2
// [RULE5] pins 2..0 high select bit 7
// [RULE6] tables act only in matching mode
// [RULE7] two-bit mode field selects bank mode
// [RULE8] tables reset to zero, outputs low
module gplut_top
  import gplut_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [15:0] gpio_level_in,
  output logic [15:0]      gpio_drive_level_out,
  output logic [15:0]      gpio_oe_n_out
);
  localparam int NBANK = 4;

  logic [7:0]  tbl_reg [NBANK];   // three-input tables indexed by bank
  logic [3:0]  la_two_reg;        // lower-a two-input table
  logic [7:0]  mode_reg;
  logic [15:0] level_reg;
  logic [15:0] oe_n_reg;
  logic [15:0] level_next;
  logic [15:0] oe_n_next;
  logic [7:0]  rd_value;
  logic        wr_strobe;
  logic [7:0]  index;
  logic [7:0]  wdata;
  logic [NBANK-1:0] lut3_bit;
  logic        lut2_bit;
  gplut_mode_t bank_mode [NBANK];

  assign wdata = avs_writedata_in[7:0];

  gplut_avmm_slave u_slave (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .address_in      (avs_address_in),
    .read_in         (avs_read_in),
    .write_in        (avs_write_in),
    .byteenable_in   (avs_byteenable_in),
    .rd_value_in     (rd_value),
    .readdata_out    (avs_readdata_out),
    .waitrequest_out (avs_waitrequest_out),
    .wr_strobe_out   (wr_strobe),
    .index_out       (index)
  );

  // per-bank lookup: index pins base+2..base, output pin base+3
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      localparam int BASE = b * `GPLUT_BANK_PINS;
      assign bank_mode[b] = gplut_mode_t'(mode_reg[2*b +: 2]); // RULE7
      gplut_lut #(.SEL_W(3)) u_lut3 (
        .table_in (tbl_reg[b]),
        .sel_in   (gpio_level_in[BASE +: 3]),
        .bit_out  (lut3_bit[b])
      );
    end
  endgenerate

  // lower-a two-input decode on pins 1..0
  gplut_lut #(.SEL_W(2)) u_lut2 (
    .table_in (la_two_reg),
    .sel_in   (gpio_level_in[1:0]),
    .bit_out  (lut2_bit)
  );

  // table registers; writes to other indices are dropped
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NBANK; i++) begin
        tbl_reg[i] <= `GPLUT_TABLE_RST; // RULE8
      end
      la_two_reg <= 4'h0; // RULE8
    end else if (wr_strobe) begin
      case (index)
        `GPLUT_IDX_UB_THREE: tbl_reg[GPLUT_BANK_UB] <= wdata;
        `GPLUT_IDX_UA_THREE: tbl_reg[GPLUT_BANK_UA] <= wdata;
        `GPLUT_IDX_LB_THREE: tbl_reg[GPLUT_BANK_LB] <= wdata;
        `GPLUT_IDX_LA_THREE: tbl_reg[GPLUT_BANK_LA] <= wdata;
        `GPLUT_IDX_LA_TWO:   la_two_reg <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // mode register, four two-bit fields
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_reg <= `GPLUT_MODE_RST;
    end else if (wr_strobe && index == `GPLUT_IDX_MODE) begin
      mode_reg <= wdata; // RULE7
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    case (index)
      `GPLUT_IDX_MODE:      rd_value = mode_reg;
      `GPLUT_IDX_LA_TWO:    rd_value = {4'h0, la_two_reg};
      `GPLUT_IDX_UB_THREE:  rd_value = tbl_reg[GPLUT_BANK_UB];
      `GPLUT_IDX_UA_THREE:  rd_value = tbl_reg[GPLUT_BANK_UA];
      `GPLUT_IDX_LB_THREE:  rd_value = tbl_reg[GPLUT_BANK_LB];
      `GPLUT_IDX_LA_THREE:  rd_value = tbl_reg[GPLUT_BANK_LA];
      `GPLUT_IDX_PIN_DRIVE: rd_value = {oe_n_reg[15], oe_n_reg[11], oe_n_reg[7],
                                        oe_n_reg[3], 3'h0, oe_n_reg[2]};
      `GPLUT_IDX_PIN_LEVEL: rd_value = {level_reg[15], level_reg[11], level_reg[7],
                                        level_reg[3], 3'h0, level_reg[2]};
      default:              rd_value = 8'h00;
    endcase
  end

  // decode drivers; split mode and reserved codes leave pins to normal i/o
  always_comb begin
    level_next = 16'h0000;
    oe_n_next  = 16'hffff;
    for (int i = 0; i < NBANK; i++) begin
      if (bank_mode[i] == GPLUT_MODE_THREE) begin // RULE6
        oe_n_next[i*`GPLUT_BANK_PINS + 3]  = 1'h0;
        level_next[i*`GPLUT_BANK_PINS + 3] = lut3_bit[i]; // RULE1 RULE2 RULE3 RULE5
      end
    end
    if (bank_mode[GPLUT_BANK_LA] == GPLUT_MODE_TWO) begin // RULE6
      oe_n_next[`GPLUT_TWO_OUT_PIN]  = 1'h0;
      level_next[`GPLUT_TWO_OUT_PIN] = lut2_bit; // RULE4
    end
  end

  // pin outputs registered, one cycle after the input levels
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_reg <= 16'h0000;
      oe_n_reg  <= 16'hffff;
    end else begin
      level_reg <= level_next;
      oe_n_reg  <= oe_n_next;
    end
  end

  assign gpio_drive_level_out = level_reg;
  assign gpio_oe_n_out        = oe_n_reg;

  // helper for checks: previous pin levels
  logic [15:0] gpio_prev_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gpio_prev_reg <= 16'h0000;
    end else begin
      gpio_prev_reg <= gpio_level_in;
    end
  end

  a_pin15_lookup: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE1
    ($past(mode_reg[7:6]) == 2'h2 && !$past(wr_strobe) && $past(rst_n_in))
      |-> (!gpio_oe_n_out[15]
           && gpio_drive_level_out[15] == tbl_reg[GPLUT_BANK_UB][gpio_prev_reg[14:12]]))
    else $error("pin 15 does not follow its table");

  a_pin7_lookup: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE2
    ($past(mode_reg[3:2]) == 2'h2 && !$past(wr_strobe) && $past(rst_n_in))
      |-> (!gpio_oe_n_out[7]
           && gpio_drive_level_out[7] == tbl_reg[GPLUT_BANK_UA][gpio_prev_reg[6:4]]))
    else $error("pin 7 does not follow its table");

  a_pin11_lookup: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE3
    ($past(mode_reg[5:4]) == 2'h2 && !$past(wr_strobe) && $past(rst_n_in))
      |-> (!gpio_oe_n_out[11]
           && gpio_drive_level_out[11] == tbl_reg[GPLUT_BANK_LB][gpio_prev_reg[10:8]]))
    else $error("pin 11 does not follow its table");

  a_pin2_lookup: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE4
    ($past(mode_reg[1:0]) == 2'h1 && !$past(wr_strobe) && $past(rst_n_in))
      |-> (!gpio_oe_n_out[2] && gpio_drive_level_out[2] == la_two_reg[gpio_prev_reg[1:0]]))
    else $error("pin 2 does not follow the two-input table");

  a_pin3_top_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE5
    (mode_reg[1:0] == 2'h2 && gpio_level_in[2:0] == 3'h7 && !wr_strobe)
      |=> (gpio_drive_level_out[3] == tbl_reg[GPLUT_BANK_LA][7] && !gpio_oe_n_out[3]))
    else $error("pin 3 misses table bit 7");

  a_normal_no_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    (mode_reg == 8'h00) |=> (gpio_oe_n_out == 16'hffff && gpio_drive_level_out == 16'h0000))
    else $error("pin driven while every bank is normal");

  a_two_mode_pins: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
    (mode_reg[1:0] == 2'h1) |=> (gpio_oe_n_out[3:0] == 4'hb))
    else $error("two-input mode drives the wrong lower-a pin");

  a_split_no_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
    (mode_reg[7:6] == 2'h3) |=> (gpio_oe_n_out[15:12] == 4'hf))
    else $error("reserved mode drives a pin");

  a_reset_zero: assert property (@(posedge clk_in) // RULE8
    (!$past(rst_n_in) && rst_n_in)
      |-> (tbl_reg[0] == 8'h00 && tbl_reg[3] == 8'h00 && la_two_reg == 4'h0
           && gpio_drive_level_out == 16'h0000))
    else $error("tables not cleared by reset");

  a_wait_one_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($rose(avs_read_in) || $rose(avs_write_in)) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("waitrequest not low for exactly one cycle");

  // full lower-a table on pin 3, not only the all-high entry
  a_pin3_lookup: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE5
    ($past(mode_reg[1:0]) == 2'h2 && !$past(wr_strobe) && $past(rst_n_in))
      |-> (!gpio_oe_n_out[3]
           && gpio_drive_level_out[3] == tbl_reg[GPLUT_BANK_LA][gpio_prev_reg[2:0]]))
    else $error("pin 3 does not follow its table");

  // outside the matching mode a decode pin is released and low
  a_pin15_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    (mode_reg[7:6] != 2'h2) |=> (gpio_oe_n_out[15] && !gpio_drive_level_out[15]))
    else $error("pin 15 driven outside three-input mode");

  a_pin7_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    (mode_reg[3:2] != 2'h2) |=> (gpio_oe_n_out[7] && !gpio_drive_level_out[7]))
    else $error("pin 7 driven outside three-input mode");

  a_pin11_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    (mode_reg[5:4] != 2'h2) |=> (gpio_oe_n_out[11] && !gpio_drive_level_out[11]))
    else $error("pin 11 driven outside three-input mode");

  a_pin3_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    (mode_reg[1:0] != 2'h2) |=> (gpio_oe_n_out[3] && !gpio_drive_level_out[3]))
    else $error("pin 3 driven outside three-input mode");

  a_pin2_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    (mode_reg[1:0] != 2'h1) |=> (gpio_oe_n_out[2] && !gpio_drive_level_out[2]))
    else $error("pin 2 driven outside two-input mode");

  // index pins other than pin 2 stay inputs in every mode; a crossed bank index would show here
  a_index_pins_free: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    ((gpio_oe_n_out & 16'h7773) == 16'h7773))
    else $error("an index pin is driven");

  a_level_needs_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    ((gpio_drive_level_out & gpio_oe_n_out) == 16'h0000))
    else $error("level high on a released pin");

  // host writes land at the edge after the strobe
  a_ub_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE1
    (wr_strobe && index == `GPLUT_IDX_UB_THREE) |=> (tbl_reg[GPLUT_BANK_UB] == $past(wdata)))
    else $error("upper-b table write lost");

  a_ua_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE2
    (wr_strobe && index == `GPLUT_IDX_UA_THREE) |=> (tbl_reg[GPLUT_BANK_UA] == $past(wdata)))
    else $error("upper-a table write lost");

  a_lb_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE3
    (wr_strobe && index == `GPLUT_IDX_LB_THREE) |=> (tbl_reg[GPLUT_BANK_LB] == $past(wdata)))
    else $error("lower-b table write lost");

  a_la3_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE5
    (wr_strobe && index == `GPLUT_IDX_LA_THREE) |=> (tbl_reg[GPLUT_BANK_LA] == $past(wdata)))
    else $error("lower-a three-input table write lost");

  a_two_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE4
    (wr_strobe && index == `GPLUT_IDX_LA_TWO)
      |=> ({4'h0, la_two_reg} == ($past(wdata) & 8'h0f)))
    else $error("two-input table write lost");

  a_mode_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
    (wr_strobe && index == `GPLUT_IDX_MODE) |=> (mode_reg == $past(wdata)))
    else $error("mode write lost");

  // status indices are read-only; a write to the drive status index must not change the mode or the two-input table
  a_read_only_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_strobe && index == `GPLUT_IDX_PIN_DRIVE) |=> ($stable(mode_reg) && $stable(la_two_reg)))
    else $error("write to a read-only index changed state");

  // byte lane 0 off means the write is dropped
  a_be_off_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (avs_write_in && !avs_byteenable_in[0])
      |=> ($stable(mode_reg) && $stable(la_two_reg) && $stable(tbl_reg[GPLUT_BANK_UB])))
    else $error("write with lane 0 off changed state");

  a_readdata_high_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (avs_readdata_out[31:8] == 24'h00_0000))
    else $error("read data upper bytes not zero");

  a_wait_needs_request: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !avs_waitrequest_out |-> ($past(avs_read_in) || $past(avs_write_in)))
    else $error("waitrequest low without a request");

  // the remaining tables, the mode field and the enables also come out of reset clear
  a_table_reset_all: assert property (@(posedge clk_in) // RULE8
    (!$past(rst_n_in) && rst_n_in)
      |-> (tbl_reg[1] == 8'h00 && tbl_reg[2] == 8'h00 && mode_reg == 8'h00
           && gpio_oe_n_out == 16'hffff))
    else $error("mode or tables not cleared by reset");

endmodule : gplut_top

/* File: sim/test_gplut_top.sv */
// test_gplut_top: self-checking bench for the lookup-table block
// assumes gplut_top with outputs one cycle behind inputs; bus waits end on waitrequest
`timescale 1ns/10ps
`include "gplut_cfg.svh"
module test_gplut_top;
  logic        clk_in;
  logic        rst_n_in;
  logic [9:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [15:0] gpio_level_in;
  logic [15:0] gpio_drive_level_out;
  logic [15:0] gpio_oe_n_out;
  int          errors;
  int          cmp_count;
  logic [7:0]  t_ub;
  logic [7:0]  t_ua;
  logic [7:0]  t_lb;
  logic [7:0]  t_la3;
  logic [3:0]  t_la2;
  logic [7:0]  modes [6];
  logic [2:0]  i3;
  logic [31:0] exp_v;

  gplut_top dut_u (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .avs_address_in       (avs_address_in),
    .avs_read_in          (avs_read_in),
    .avs_write_in         (avs_write_in),
    .avs_writedata_in     (avs_writedata_in),
    .avs_byteenable_in    (avs_byteenable_in),
    .avs_readdata_out     (avs_readdata_out),
    .avs_waitrequest_out  (avs_waitrequest_out),
    .gpio_level_in        (gpio_level_in),
    .gpio_drive_level_out (gpio_drive_level_out),
    .gpio_oe_n_out        (gpio_oe_n_out)
  );

  // free-running 100 MHz clock
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // one access; an idle edge first so a strobe is never dropped and raised in one step
  task automatic bus_op(input logic wr, input logic [7:0] idx, input logic [7:0] wdata,
                        input logic [3:0] be, output logic [31:0] rdata);
    @(posedge clk_in);
    avs_address_in    <= {idx, 2'h0};
    avs_writedata_in  <= {24'h0, wdata};
    avs_byteenable_in <= be;
    avs_write_in      <= wr;
    avs_read_in       <= !wr;
    // hold until waitrequest is sampled low; only the watchdog ends a wait that never comes
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'h0);
    rdata = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in  <= 1'h0;
  endtask : bus_op

  task automatic wr(input logic [7:0] idx, input logic [7:0] data, input logic [3:0] be);
    logic [31:0] d;
    bus_op(1'h1, idx, data, be, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus_op(1'h0, idx, 8'h00, 4'hf, d);
    check(name, d, exp);
  endtask : rd_chk

  // reference decode, built from the table bits held by the bench
  function automatic logic [31:0] model(input logic [7:0] m, input logic [15:0] p);
    logic [15:0] oe;
    logic [15:0] lv;
    oe = 16'hffff;
    lv = 16'h0000;
    oe[15] = (m[7:6] != 2'h2);
    lv[15] = (m[7:6] == 2'h2) & t_ub[p[14:12]];
    oe[7]  = (m[3:2] != 2'h2);
    lv[7]  = (m[3:2] == 2'h2) & t_ua[p[6:4]];
    oe[11] = (m[5:4] != 2'h2);
    lv[11] = (m[5:4] == 2'h2) & t_lb[p[10:8]];
    oe[2]  = (m[1:0] != 2'h1);
    lv[2]  = (m[1:0] == 2'h1) & t_la2[p[1:0]];
    oe[3]  = (m[1:0] != 2'h2);
    lv[3]  = (m[1:0] == 2'h2) & t_la3[p[2:0]];
    return {oe, lv};
  endfunction : model

  // drive pins at an edge; the second edge after sees what the first one launched
  task automatic pins(input logic [7:0] m, input logic [15:0] lvl);
    gpio_level_in <= lvl;
    @(posedge clk_in);
    @(posedge clk_in);
    exp_v = model(m, lvl);
    check("gpio_oe_n_out", {16'h0, gpio_oe_n_out}, {16'h0, exp_v[31:16]});
    check("gpio_drive_level_out", {16'h0, gpio_drive_level_out}, {16'h0, exp_v[15:0]});
  endtask : pins

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    {t_ub, t_ua, t_lb, t_la3, t_la2} = '0;
    modes = '{8'ha9, 8'haa, 8'h00, 8'h55, 8'hff, 8'h9e};
    rst_n_in = 1'h0;
    avs_address_in = 10'h000;
    {avs_read_in, avs_write_in} = 2'h0;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'h0;
    gpio_level_in = 16'h0000;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(posedge clk_in);
    for (int i = 8'h23; i <= 8'h27; i++) rd_chk("table", i[7:0], 32'h0);
    rd_chk("mode", `GPLUT_IDX_MODE, 32'h0);
    wr(8'h2f, 8'hff, 4'h1);
    rd_chk("unmapped", 8'h2f, 32'h0);
    wr(`GPLUT_IDX_PIN_DRIVE, 8'h00, 4'h1);
    rd_chk("drive status", `GPLUT_IDX_PIN_DRIVE, 32'hf1);
    // zero tables: enabled outputs drive low
    wr(`GPLUT_IDX_MODE, 8'haa, 4'h1);
    pins(8'haa, 16'h7777);
    wr(`GPLUT_IDX_UB_THREE, 8'hff, 4'h0);
    rd_chk("byteenable off", `GPLUT_IDX_UB_THREE, 32'h0);
    {t_ub, t_ua, t_lb, t_la3, t_la2} = {8'ha6, 8'h3c, 8'h5a, 8'h81, 4'h6};
    wr(`GPLUT_IDX_UB_THREE, t_ub, 4'h1);
    wr(`GPLUT_IDX_UA_THREE, t_ua, 4'h1);
    wr(`GPLUT_IDX_LB_THREE, t_lb, 4'h1);
    wr(`GPLUT_IDX_LA_THREE, t_la3, 4'h1);
    wr(`GPLUT_IDX_LA_TWO, {4'h0, t_la2}, 4'h1);
    rd_chk("ub table", `GPLUT_IDX_UB_THREE, {24'h0, t_ub});
    rd_chk("la2 table", `GPLUT_IDX_LA_TWO, {28'h0, t_la2});
    // every mode code per bank, each bank on its own index so crossed wiring shows
    foreach (modes[k]) begin
      wr(`GPLUT_IDX_MODE, modes[k], 4'h1);
      rd_chk("mode", `GPLUT_IDX_MODE, {24'h0, modes[k]});
      for (int i = 0; i < 8; i++) begin
        i3 = i[2:0];
        pins(modes[k], {1'h1, i3, 1'h1, ~i3, 1'h1, i3 + 3'h1, 1'h0, i3 ^ 3'h3});
      end
    end
    wr(`GPLUT_IDX_MODE, 8'h02, 4'h1);
    pins(8'h02, 16'h0007);
    // second reset in mid-run clears tables and mode
    rst_n_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(posedge clk_in);
    rd_chk("table after reset", `GPLUT_IDX_UB_THREE, 32'h0);
    pins(8'h00, 16'hffff);
    test_done();
  end
endmodule : test_gplut_top
